// file: hw/bapst_pkg.sv
package bapst_pkg;
  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 8;
  // register offsets (own choice)
  localparam logic [3:0]  OFS_ACK_MASK    = 4'h0;
  localparam logic [3:0]  OFS_ACK_DATA    = 4'h1;
  localparam logic [3:0]  OFS_FLAGS_BYTE  = 4'h2;
  localparam logic [3:0]  OFS_CLR_POLICY  = 4'h3;
  localparam logic [3:0]  OFS_STATUS      = 4'h4;
  localparam logic [7:0]  ACK_DATA_RST    = 8'h00;
  localparam logic [7:0]  FLAGS_RST       = 8'h00;
  localparam logic [7:0]  POLICY_RST      = 8'h00;
  localparam logic [7:0]  READ_ZERO       = 8'h00;
  localparam int          FLAG_VALID_BIT  = 7;
  localparam int          POL_PEF_BIT     = 4;
  localparam int          POL_TIMEOUT_BIT = 3;
  localparam int          POL_WDOG_BIT    = 2;
  localparam int          POL_BUTTON_BIT  = 1;
  localparam int          POL_PWRUP_BIT   = 0;
  localparam logic [4:0]  POLICY_MASK     = 5'h1F;
  localparam longint      CLK_HZ          = 25000000;
  localparam longint      TIMEOUT_S       = 60;
  localparam longint      TIMEOUT_CYC     = TIMEOUT_S * CLK_HZ;
endpackage : bapst_pkg

// file: hw/bapst_top.sv
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module bapst_top #(
  parameter longint TIMEOUT_CYCLES = bapst_pkg::TIMEOUT_CYC
) (
  input  wire logic                        clock,
  input  wire logic                        rstn,
  input  wire logic [bapst_pkg::ADDR_W-1:0] addr,
  input  wire logic [bapst_pkg::DATA_W-1:0] wdata,
  input  wire logic                        wr_stb,
  input  wire logic                        rd_stb,
  output logic      [bapst_pkg::DATA_W-1:0] rdata,
  input  wire logic                        chassis_cmd,
  input  wire logic                        pef_reset,
  input  wire logic                        wdog_reset,
  input  wire logic                        button_reset,
  input  wire logic                        power_up,
  output logic                             flags_valid
);
  import bapst_pkg::*;

  logic [7:0]  ack_data_r;
  logic [7:0]  mask_hold_r;
  logic [7:0]  flags_r;
  logic [4:0]  policy_r;
  logic [31:0] tmo_cnt_r;
  logic [4:0]  ev_s1_r;
  logic [4:0]  ev_s2_r;
  logic [4:0]  ev_s3_r;
  logic        tmo_hit;
  logic        auto_clr;
  logic [4:0]  ev_rise;

  //////////////////////////////////////////////////////////////////////////////
  // external events are pins: synchronise, then edge detect on stage two
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ev_s1_r <= 5'h00;
      ev_s2_r <= 5'h00;
      ev_s3_r <= 5'h00;
    end else begin
      ev_s1_r <= {chassis_cmd, pef_reset, wdog_reset, button_reset, power_up};
      ev_s2_r <= ev_s1_r;
      ev_s3_r <= ev_s2_r;
    end
  end
  assign ev_rise = ev_s2_r & ~ev_s3_r;

  //////////////////////////////////////////////////////////////////////////////
  // mask is a write-only side field; held only until the data write
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn)
      mask_hold_r <= READ_ZERO;
    else if (wr_stb && addr == OFS_ACK_MASK)
      mask_hold_r <= wdata;
    else if (wr_stb && addr == OFS_ACK_DATA)
      mask_hold_r <= READ_ZERO;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn)
      ack_data_r <= ACK_DATA_RST;
    else if (wr_stb && addr == OFS_ACK_DATA)
      ack_data_r <= (ack_data_r & ~mask_hold_r) | (wdata & mask_hold_r);
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn)
      policy_r <= POLICY_RST[4:0];
    else if (wr_stb && addr == OFS_CLR_POLICY)
      policy_r <= wdata[4:0] & POLICY_MASK;
  end

  // countdown restarts on every chassis command
  assign tmo_hit = (tmo_cnt_r >= 32'(TIMEOUT_CYCLES - 1));
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn)
      tmo_cnt_r <= 32'h00000000;
    else if (ev_rise[4] || !flags_r[FLAG_VALID_BIT] || tmo_hit)
      tmo_cnt_r <= 32'h00000000;
    else
      tmo_cnt_r <= tmo_cnt_r + 32'h00000001;
  end

  assign auto_clr = (tmo_hit && !policy_r[POL_TIMEOUT_BIT])
                 || (ev_rise[3] && !policy_r[POL_PEF_BIT])
                 || (ev_rise[2] && !policy_r[POL_WDOG_BIT])
                 || (ev_rise[1] && !policy_r[POL_BUTTON_BIT])
                 || (ev_rise[0] && !policy_r[POL_PWRUP_BIT]);

  // a software set in the same cycle wins over the automatic clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn)
      flags_r <= FLAGS_RST;
    else if (wr_stb && addr == OFS_FLAGS_BYTE)
      flags_r <= wdata;
    else if (auto_clr)
      flags_r[FLAG_VALID_BIT] <= 1'b0;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn)
      flags_valid <= 1'b0;
    else
      flags_valid <= (wr_stb && addr == OFS_FLAGS_BYTE) ? wdata[FLAG_VALID_BIT]
                   : (auto_clr ? 1'b0 : flags_r[FLAG_VALID_BIT]);
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn)
      rdata <= READ_ZERO;
    else if (rd_stb) begin
      unique case (addr)
        OFS_ACK_MASK:   rdata <= READ_ZERO;
        OFS_ACK_DATA:   rdata <= ack_data_r;
        OFS_FLAGS_BYTE: rdata <= flags_r;
        OFS_CLR_POLICY: rdata <= {3'h0, policy_r};
        OFS_STATUS:     rdata <= {7'h00, tmo_hit};
        default:        rdata <= READ_ZERO;
      endcase
    end else
      rdata <= READ_ZERO;
  end

  //////////////////////////////////////////////////////////////////////////////
  // two-step ack update as the bus delivers it: mask, one idle cycle, data
  sequence s_mask_wr;
    wr_stb && addr == OFS_ACK_MASK;
  endsequence

  sequence s_data_wr;
    wr_stb && addr == OFS_ACK_DATA;
  endsequence

  sequence s_mask_then_data;
    s_mask_wr ##1 !wr_stb ##1 s_data_wr;
  endsequence

  sequence s_data_then_data;
    s_data_wr ##1 !wr_stb ##1 s_data_wr;
  endsequence

  a_mask_write: assert property (@(posedge clock) disable iff (!rstn)
    (wr_stb && addr == OFS_ACK_DATA) |=>
      ((ack_data_r ^ $past(ack_data_r)) & ~$past(mask_hold_r)) == 8'h00)
    else $error("unmasked ack bit changed");
  a_mask_reads_zero: assert property (@(posedge clock) disable iff (!rstn)
    (rd_stb && addr == OFS_ACK_MASK) |=> rdata == 8'h00)
    else $error("mask read not zero");
  a_ack_read_back: assert property (@(posedge clock) disable iff (!rstn)
    (rd_stb && addr == OFS_ACK_DATA) |=> rdata == $past(ack_data_r))
    else $error("ack read mismatch");
  a_ack_hold: assert property (@(posedge clock) disable iff (!rstn)
    !(wr_stb && addr == OFS_ACK_DATA) |=> $stable(ack_data_r))
    else $error("ack changed without write");
  a_pef_clear: assert property (@(posedge clock) disable iff (!rstn)
    (ev_rise[3] && !policy_r[POL_PEF_BIT] && !wr_stb) |=> !flags_r[FLAG_VALID_BIT])
    else $error("pef did not clear valid");
  a_pef_keep: assert property (@(posedge clock) disable iff (!rstn)
    (auto_clr == 1'b0 && !wr_stb && flags_r[FLAG_VALID_BIT]) |=> flags_r[FLAG_VALID_BIT])
    else $error("valid lost without cause");
  a_tmo_clear: assert property (@(posedge clock) disable iff (!rstn)
    (tmo_hit && !policy_r[POL_TIMEOUT_BIT] && !wr_stb) |=> !flags_valid)
    else $error("timeout did not clear valid");
  a_cmd_restart: assert property (@(posedge clock) disable iff (!rstn)
    ev_rise[4] |=> tmo_cnt_r == 32'h00000000)
    else $error("countdown not restarted");
  a_valid_out: assert property (@(posedge clock) disable iff (!rstn)
    1'b1 |=> flags_valid == flags_r[FLAG_VALID_BIT])
    else $error("valid output mismatch");

  a_masked_take: assert property (@(posedge clock) disable iff (!rstn)
    s_mask_then_data |=> ((ack_data_r ^ $past(wdata)) & $past(wdata, 3)) == 8'h00)
    else $error("enabled ack bit not written");

  // the mask is spent by the first data write; a second one must not reuse it
  a_mask_consumed: assert property (@(posedge clock) disable iff (!rstn)
    s_data_then_data |=> $stable(ack_data_r))
    else $error("mask reused by later write");

  a_rdata_idle: assert property (@(posedge clock) disable iff (!rstn)
    !rd_stb |=> rdata == READ_ZERO)
    else $error("read data without read");

  a_evt_clear: assert property (@(posedge clock) disable iff (!rstn)
    (((ev_rise[2] && !policy_r[POL_WDOG_BIT]) || (ev_rise[1] && !policy_r[POL_BUTTON_BIT])
      || (ev_rise[0] && !policy_r[POL_PWRUP_BIT])) && !wr_stb)
      |=> !flags_r[FLAG_VALID_BIT])
    else $error("reset event did not clear valid");

  a_flags_write: assert property (@(posedge clock) disable iff (!rstn)
    (wr_stb && addr == OFS_FLAGS_BYTE) |=> flags_valid == $past(wdata[FLAG_VALID_BIT]))
    else $error("software write to valid lost");

  a_cnt_idle: assert property (@(posedge clock) disable iff (!rstn)
    !flags_r[FLAG_VALID_BIT] |=> tmo_cnt_r == 32'h00000000)
    else $error("countdown runs while invalid");

  a_cnt_bound: assert property (@(posedge clock) disable iff (!rstn)
    tmo_cnt_r < 32'(TIMEOUT_CYCLES))
    else $error("countdown past its limit");

  a_policy_read: assert property (@(posedge clock) disable iff (!rstn)
    (rd_stb && addr == OFS_CLR_POLICY) |=> rdata[7:5] == 3'h0)
    else $error("policy upper bits not zero");

  a_status_read: assert property (@(posedge clock) disable iff (!rstn)
    (rd_stb && addr == OFS_STATUS) |=> rdata[7:1] == 7'h00)
    else $error("status upper bits not zero");

endmodule : bapst_top

// file: verif/bapst_tb_top.sv
`timescale 1ns/1ps
module bapst_tb_top;
  import bapst_pkg::*;
  logic              clock       = 1'b0;
  logic              rstn        = 1'b0;
  logic [ADDR_W-1:0] addr        = '0;
  logic [DATA_W-1:0] wdata       = '0;
  logic              wr_stb      = 1'b0;
  logic              rd_stb      = 1'b0;
  logic [4:0]        ev          = '0;
  logic [DATA_W-1:0] rdata;
  logic              flags_valid;
  int                mismatches  = 0;
  int                n_compared  = 0;
  int                pol_bit [4] = '{0, 1, 2, 4};
  localparam int     TMO_CYC     = 50;
  always #20 clock = ~clock;
  // short countdown keeps the timeout scenario within a few hundred cycles
  bapst_top #(.TIMEOUT_CYCLES(TMO_CYC)) dut (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .chassis_cmd(ev[4]), .pef_reset(ev[3]),
    .wdog_reset(ev[2]), .button_reset(ev[1]), .power_up(ev[0]), .flags_valid(flags_valid));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // look just after the edge so the sample never races the flop update
  task automatic chkv(input logic exp);
    #1 chk({7'h00, flags_valid}, {7'h00, exp});
  endtask : chkv
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rd
  task automatic ack(input logic [7:0] m, input logic [7:0] d);
    wr(OFS_ACK_MASK, m);
    wr(OFS_ACK_DATA, d);
  endtask : ack
  // pins pass a two-flop sync, so hold the event long enough to be seen
  task automatic pulse(input int i);
    @(posedge clock);
    ev[i] <= 1'b1;
    repeat (4) @(posedge clock);
    ev[i] <= 1'b0;
    repeat (8) @(posedge clock);
  endtask : pulse
  task automatic setv();
    wr(OFS_FLAGS_BYTE, 8'h80);
    repeat (2) @(posedge clock);
    #1 chk({7'h00, flags_valid}, 8'h01);
  endtask : setv
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    rd(OFS_ACK_DATA, ACK_DATA_RST);
    ack(8'hFF, 8'hFF);
    rd(OFS_ACK_DATA, 8'hFF);
    rd(OFS_ACK_MASK, READ_ZERO);
    ack(8'h01, 8'h00);
    rd(OFS_ACK_DATA, 8'hFE);
    wr(OFS_ACK_DATA, 8'h00);
    rd(OFS_ACK_DATA, 8'hFE);
    wr(OFS_ACK_MASK, 8'h18);
    rd(OFS_ACK_MASK, READ_ZERO);
    wr(OFS_ACK_DATA, 8'h00);
    rd(OFS_ACK_DATA, 8'hE6);
    rd(OFS_ACK_MASK, READ_ZERO);
    rd(4'hF, READ_ZERO);
    wr(OFS_CLR_POLICY, 8'hFF);
    rd(OFS_CLR_POLICY, 8'h1F);
    wr(OFS_CLR_POLICY, 8'h00);
    setv();
    rd(OFS_FLAGS_BYTE, 8'h80);
    repeat (4) begin
      pulse(4);
      repeat (20) @(posedge clock);
    end
    chkv(1'b1);
    repeat (60) @(posedge clock);
    chkv(1'b0);
    wr(OFS_CLR_POLICY, 8'h08);
    setv();
    // count starts at the valid write, so the status read lands on the first hit of the countdown
    repeat (TMO_CYC - 4) @(posedge clock);
    rd(OFS_STATUS, 8'h01);
    repeat (9) @(posedge clock);
    chkv(1'b1);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CLR_POLICY, 8'(8'h08 | (8'h01 << pol_bit[i])));
      setv();
      pulse(i);
      chkv(1'b1);
      wr(OFS_CLR_POLICY, 8'h08);
      setv();
      pulse(i);
      chkv(1'b0);
    end
    setv();
    @(posedge clock);
    rstn <= 1'b0;
    @(posedge clock);
    rstn <= 1'b1;
    rd(OFS_ACK_DATA, ACK_DATA_RST);
    rd(OFS_FLAGS_BYTE, FLAGS_RST);
    rd(OFS_CLR_POLICY, POLICY_RST);
    chkv(1'b0);
    summarize();
  end
endmodule : bapst_tb_top
